// ### rtl/hpp_params.svh
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH

// ----------------------------------------------------------------
// Bus geometry and address map
// ----------------------------------------------------------------
`define HPP_AW 11
`define HPP_DW 8
`define HPP_REG_SPAN 11'h0016
`define HPP_REG_STATUS 11'h0000
`define HPP_REG_EOI 11'h0001
`define HPP_CS_BASE 5'h00

// ----------------------------------------------------------------
// Timing in device clock cycles and in nanoseconds
// ----------------------------------------------------------------
`define HPP_CLK_NS 100
`define HPP_GAP_SHORT_NS 1000
`define HPP_GAP_LONG_NS 1000000
`define HPP_GAP_SHORT_CYC ((`HPP_GAP_SHORT_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_GAP_LONG_CYC ((`HPP_GAP_LONG_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_RAM_LAT 3'h3
`define HPP_REG_LAT 3'h4
`define HPP_RDY_NORMAL 3'h5
`define HPP_RDY_EARLY 3'h4
`define HPP_WR_SPACING 6
`define HPP_RESET_MIN_CYC 400

`endif

// ### rtl/hpp_pkg.sv
package hpp_pkg;

  typedef logic [7:0] hpp_data_t;
  typedef logic [10:0] hpp_addr_t;

  // Gray order along idle -> read -> hold, write beside idle
  typedef enum logic [1:0] {
    S_IDLE  = 2'h0,
    S_READ  = 2'h1,
    S_HOLD  = 2'h3,
    S_WRITE = 2'h2
  } hpp_state_e;

  function automatic logic hpp_cs_hit(input logic [4:0] upper, input logic [4:0] base);
    return upper == base;
  endfunction

endpackage

// ### rtl/hpp_irq_if.sv
`timescale 1ns/1ps
interface hpp_irq_if;
  logic event_pulse;
  logic eoi_pulse;
  logic timebase_long;
  logic gap_busy;
  logic irq_low;

  modport core (output event_pulse, output eoi_pulse, output timebase_long, input gap_busy, input irq_low);
  modport gap (input event_pulse, input eoi_pulse, input timebase_long, output gap_busy, output irq_low);
endinterface

// ### rtl/hpp_pin_sync.sv
`timescale 1ns/1ps
module hpp_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // A bit moves only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      o_q <= '1;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_q <= (s3_q & agree) | (o_q & ~agree);
    end
  end
endmodule // hpp_pin_sync

// ### rtl/hpp_irq_gap.sv
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_irq_gap #(
  parameter int unsigned LONG_CYC = `HPP_GAP_LONG_CYC
) (
  input wire logic i_clock,
  input wire logic i_reset,
  hpp_irq_if.gap bus
);
  localparam int unsigned CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] SHORT_LD = CW'(`HPP_GAP_SHORT_CYC);
  localparam logic [CW-1:0] LONG_LD = CW'(LONG_CYC);

  logic pending_q;
  logic irq_q;
  logic [CW-1:0] gap_q;
  logic fire;

  assign fire = pending_q & ~irq_q & (gap_q == '0) & ~bus.eoi_pulse;
  assign bus.irq_low = ~irq_q;
  assign bus.gap_busy = gap_q != '0;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pending_q <= 1'b0;
      irq_q <= 1'b0;
      gap_q <= '0;
    end else begin
      // A new event in the firing cycle keeps the pending flag set
      pending_q <= bus.event_pulse | (pending_q & ~fire);
      if (bus.eoi_pulse) begin
        irq_q <= 1'b0;
        gap_q <= bus.timebase_long ? LONG_LD : SHORT_LD;
      end else begin
        irq_q <= irq_q | fire;
        if (gap_q != '0) begin
          gap_q <= gap_q - CW'(1);
        end
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_gap_short_hold: assert property (bus.eoi_pulse && !bus.timebase_long |=> irq_q == 1'b0 [*8])
    else $error("interrupt reasserted inside short gap");
  a_gap_long_load: assert property (bus.eoi_pulse && bus.timebase_long |=> gap_q == LONG_LD)
    else $error("long gap not loaded after end of interrupt");
  a_gap_quiet: assert property (gap_q != '0 |=> !$rose(irq_q))
    else $error("interrupt rose while gap still running");
endmodule // hpp_irq_gap

// ### rtl/hpp_host_port.sv
`timescale 1ns/1ps
`include "hpp_params.svh"
module hpp_host_port #(
  parameter int unsigned GAP_LONG_CYC = `HPP_GAP_LONG_CYC,
  parameter logic [4:0] CS_BASE = `HPP_CS_BASE
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_multiplexed_sync_bus_mode,
  input wire logic i_early_ready,
  input wire logic i_irq_gap_timebase_sel,
  input wire logic i_irq_event,
  input wire logic i_read_strobe_low,
  input wire logic i_write_strobe_low,
  input wire logic i_chip_select_low,
  input wire logic i_addr_latch_enable,
  input wire logic [15:0] i_addr,
  input wire hpp_pkg::hpp_data_t i_data,
  output hpp_pkg::hpp_data_t o_data,
  output logic o_data_oe_low,
  output logic o_ready_out_low,
  output logic o_irq_low
);
  import hpp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  localparam int unsigned SW = 28;
  localparam int unsigned RN = 22;

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_f;
  logic [3:0] strb_prev_q;

  // Latch strobe enters inverted, so the all-ones reset of the filter reads as its idle level
  assign pins_raw = {i_read_strobe_low, i_write_strobe_low, i_chip_select_low, ~i_addr_latch_enable, i_addr, i_data};

  hpp_pin_sync #(.W(SW)) u_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_d(pins_raw),
    .o_q(pins_f)
  );

  logic rd_act;
  logic wr_act;
  logic cs_act;
  logic ale;
  logic rd_act_prev;
  logic wr_act_prev;
  logic ale_prev;
  logic [15:0] addr_f;
  hpp_data_t data_f;

  assign rd_act = ~pins_f[27];
  assign wr_act = ~pins_f[26];
  assign cs_act = ~pins_f[25];
  assign ale = ~pins_f[24];
  assign addr_f = pins_f[23:8];
  assign data_f = pins_f[7:0];
  assign rd_act_prev = ~strb_prev_q[3];
  assign wr_act_prev = ~strb_prev_q[2];
  assign ale_prev = ~strb_prev_q[0];

  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic ale_fall;

  assign rd_fall = rd_act & ~rd_act_prev;
  assign wr_fall = wr_act & ~wr_act_prev;
  assign wr_rise = ~wr_act & wr_act_prev;
  assign ale_fall = ~ale & ale_prev;

  // ----------------------------------------------------------------
  // Mode strap, taken on the first edge after reset release
  // ----------------------------------------------------------------
  logic mode_valid_q;
  logic mux_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      strb_prev_q <= 4'hF;
      mode_valid_q <= 1'b0;
      mux_q <= 1'b0;
    end else begin
      strb_prev_q <= pins_f[27:24];
      mode_valid_q <= 1'b1;
      if (!mode_valid_q) begin
        mux_q <= i_multiplexed_sync_bus_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiplexed address latch and internal chip select
  // ----------------------------------------------------------------
  hpp_data_t mux_low_q;
  logic [2:0] mux_hi_q;
  logic mux_hit_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      mux_low_q <= 8'h00;
      mux_hi_q <= 3'h0;
      mux_hit_q <= 1'b0;
    end else if (ale_fall && mux_q) begin
      mux_low_q <= data_f;
      mux_hi_q <= addr_f[10:8];
      mux_hit_q <= hpp_cs_hit(addr_f[15:11], CS_BASE);
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  hpp_state_e state_q;
  hpp_state_e state_d;
  hpp_addr_t acc_addr;
  logic sel;
  logic is_reg;
  logic start_rd;
  logic start_wr;
  logic open_wr;

  assign acc_addr = mux_q ? {mux_hi_q, mux_low_q} : addr_f[10:0];
  assign sel = mux_q ? mux_hit_q : cs_act;
  assign is_reg = acc_addr < `HPP_REG_SPAN;
  assign start_rd = mode_valid_q & rd_fall & sel & (state_q == S_IDLE);
  // Writes commit in one edge, so a six-clock rise spacing never overlaps two
  assign start_wr = mode_valid_q & wr_rise & sel & (state_q inside {S_IDLE, S_WRITE});
  assign open_wr = mode_valid_q & wr_fall & sel & ~mux_q & (state_q == S_IDLE);

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  logic [2:0] cnt_q;
  logic rd_reg_q;
  hpp_addr_t rd_addr_q;
  logic [2:0] data_lat;
  logic [2:0] rdy_lat;
  logic load_data;
  logic rdy_hit;
  logic ready_q;
  logic drive_q;

  assign data_lat = rd_reg_q ? `HPP_REG_LAT : `HPP_RAM_LAT;
  assign rdy_lat = i_early_ready ? `HPP_RDY_EARLY : `HPP_RDY_NORMAL;
  assign load_data = (state_q == S_READ) & rd_act & (cnt_q == data_lat);
  assign rdy_hit = (state_q == S_READ) & rd_act & (cnt_q == rdy_lat);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (start_rd) begin
          state_d = S_READ;
        end else if (open_wr) begin
          state_d = S_WRITE;
        end
      end
      S_READ: begin
        if (!rd_act) begin
          state_d = S_IDLE;
        end else if (rdy_hit) begin
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!rd_act) begin
          state_d = S_IDLE;
        end
      end
      S_WRITE: begin
        if (!wr_act) begin
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      rd_reg_q <= 1'b0;
      rd_addr_q <= 11'h000;
    end else begin
      state_q <= state_d;
      if (start_rd) begin
        cnt_q <= 3'h1;
        rd_reg_q <= is_reg;
        rd_addr_q <= acc_addr;
      end else if (state_q == S_READ) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // Ready only exists in async memory mode; released with the strobe
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ~mux_q & ((rdy_hit | (ready_q & state_q == S_HOLD & rd_act))
                 | open_wr | (ready_q & state_q == S_WRITE & wr_act));
    end
  end

  assign o_ready_out_low = ~(ready_q & ~(i_read_strobe_low & i_write_strobe_low));

  // ----------------------------------------------------------------
  // Storage: RAM array and register bank
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH = 1 << `HPP_AW;

  hpp_irq_if u_irq_bus ();
  hpp_data_t ram_q [DEPTH];
  hpp_data_t regs_q [RN];
  hpp_data_t status;
  hpp_data_t rd_word;
  logic eoi_wr;

  assign status = {3'h0, mux_q, u_irq_bus.gap_busy, ~u_irq_bus.irq_low, state_q};
  assign rd_word = !rd_reg_q ? ram_q[rd_addr_q] :
                   (rd_addr_q == `HPP_REG_STATUS) ? status : regs_q[rd_addr_q[4:0]];
  assign eoi_wr = start_wr & (acc_addr == `HPP_REG_EOI);

  // Memory keeps its contents across reset; only the register bank clears
  always_ff @(posedge i_clock) begin
    if (start_wr && !is_reg) begin
      ram_q[acc_addr] <= data_f;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < RN; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (start_wr && is_reg && acc_addr != `HPP_REG_STATUS) begin
      regs_q[acc_addr[4:0]] <= data_f;
    end
  end

  // ----------------------------------------------------------------
  // Read data and bus drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_data <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      if (load_data) begin
        o_data <= rd_word;
      end
      drive_q <= (drive_q | load_data) & (state_d != S_IDLE);
    end
  end

  // Raw pin gate so the bus floats the moment the strobe goes high
  assign o_data_oe_low = ~(drive_q & ~i_read_strobe_low);

  // ----------------------------------------------------------------
  // Interrupt spacing
  // ----------------------------------------------------------------
  assign u_irq_bus.event_pulse = i_irq_event;
  assign u_irq_bus.eoi_pulse = eoi_wr;
  assign u_irq_bus.timebase_long = i_irq_gap_timebase_sel;
  assign o_irq_low = u_irq_bus.irq_low;

  hpp_irq_gap #(.LONG_CYC(GAP_LONG_CYC)) u_gap (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .bus(u_irq_bus)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_rd_normal;
    start_rd && !i_early_ready && !mux_q ##1 (rd_act && state_q == S_READ) [*5];
  endsequence

  sequence s_rd_early;
    start_rd && i_early_ready && !mux_q ##1 (rd_act && state_q == S_READ) [*4];
  endsequence

  sequence s_ram_read;
    start_rd && !is_reg ##1 (rd_act && state_q == S_READ) [*3];
  endsequence

  a_ready_normal: assert property (s_rd_normal |=> ready_q)
    else $error("normal ready not given five clocks after read start");
  a_ready_early: assert property (s_rd_early |=> ready_q)
    else $error("early ready not given four clocks after read start");
  a_ready_not_soon: assert property (start_rd |=> !ready_q [*3])
    else $error("ready came before the read latency");
  a_ram_latency: assert property (s_ram_read |=> drive_q)
    else $error("RAM read data not ready after three clocks");
  a_reg_latency: assert property (start_rd && is_reg |=> !drive_q [*4])
    else $error("register read data came too early");
  a_ready_release: assert property (ready_q && !rd_act && !wr_act |=> !ready_q)
    else $error("ready held after strobe release");
  a_bus_float: assert property (i_read_strobe_low || state_q == S_IDLE |-> o_data_oe_low)
    else $error("data bus driven without an active read");
  a_mux_latch: assert property (ale_fall && mux_q |=> mux_low_q == $past(data_f))
    else $error("low address not captured on latch fall");
  a_mux_select: assert property (ale_fall && mux_q |=> mux_hi_q == $past(addr_f[10:8])
    && mux_hit_q == ($past(addr_f[15:11]) == CS_BASE))
    else $error("upper address or select not taken at latch fall");
  a_write_commit: assert property (start_wr && !is_reg |=> ram_q[$past(acc_addr)] == $past(data_f))
    else $error("write not committed on strobe rise");
  a_mode_fixed: assert property (mode_valid_q |=> $stable(mux_q))
    else $error("bus mode changed after reset");
  a_ready_mux_idle: assert property (mux_q && mode_valid_q |-> o_ready_out_low)
    else $error("ready driven in multiplexed mode");
endmodule // hpp_host_port

// ### dv/hpp_host_model.sv
`timescale 1ns/1ps
// Host processor on the parallel bus; changes pins only at falling clock edges
module hpp_host_model import hpp_pkg::*; (
  input wire logic i_clock,
  input wire logic i_ready_low,
  input wire logic i_oe_low,
  input wire hpp_pkg::hpp_data_t i_bus,
  output logic o_rd_low,
  output logic o_wr_low,
  output logic o_cs_low,
  output logic o_ale,
  output logic [15:0] o_addr,
  output hpp_pkg::hpp_data_t o_data
);
  logic mux = 1'b0;

  initial begin
    o_rd_low = 1'b1;
    o_wr_low = 1'b1;
    o_cs_low = 1'b1;
    o_ale = 1'b0;
    o_addr = 16'hffff;
    o_data = 8'h5a;
  end

  // ----
  // Address phase
  // ----
  task automatic latch(input logic [15:0] a);
    @(negedge i_clock);
    o_ale = 1'b1;
    o_addr = a;
    o_data = a[7:0];
    // Latch strobe spans three device clocks, as a slower host clock would
    repeat (3) @(negedge i_clock);
    o_ale = 1'b0;
    // Address stays put until the synchroniser has seen the strobe fall
    repeat (4) @(negedge i_clock);
    o_data = ~a[7:0];
  endtask

  // ----
  // Data phases
  // ----
  task automatic rd(input logic [15:0] a, output hpp_data_t d, output int rl, output int ol, output logic ok);
    int n;
    if (mux) latch(a);
    @(negedge i_clock);
    o_addr = a;
    o_cs_low = mux;
    o_rd_low = 1'b0;
    rl = 0;
    ol = 0;
    d = 8'h00;
    // Strobe held until ready, or 12 clocks where no ready comes
    // Sampled at the falling edge, once the rising edge's outputs have settled
    for (n = 1; n <= 12; n++) begin
      @(negedge i_clock);
      if (ol == 0 && i_oe_low === 1'b0) ol = n;
      if (i_oe_low === 1'b0) d = i_bus;
      if (i_ready_low === 1'b0) rl = n;
      if (!mux && rl != 0) break;
    end
    o_rd_low = 1'b1;
    o_cs_low = 1'b1;
    #1 ok = (i_oe_low === 1'b1) && (i_ready_low === 1'b1);
    repeat (6) @(negedge i_clock);
    ok = ok && (i_ready_low === 1'b1);
    o_addr = ~a;
  endtask

  task automatic wr(input logic [15:0] a, input hpp_data_t dt, input logic cs, output logic ok);
    int n;
    if (mux) latch(a);
    @(negedge i_clock);
    o_addr = a;
    o_data = dt;
    o_cs_low = cs;
    o_wr_low = 1'b0;
    for (n = 0; n < 8; n++) begin
      @(negedge i_clock);
      if (!mux && !cs && i_ready_low === 1'b0) break;
    end
    o_wr_low = 1'b1;
    #1 ok = (i_ready_low === 1'b1);
    // Data held across the rise; also keeps rises six clocks apart
    repeat (6) @(negedge i_clock);
    ok = ok && (i_ready_low === 1'b1);
    o_cs_low = 1'b1;
    o_data = ~dt;
    o_addr = ~a;
  endtask
endmodule // hpp_host_model

// ### dv/hpp_host_port_tb.sv
`timescale 1ns/1ps
module hpp_host_port_tb import hpp_pkg::*;;
  localparam int GAP_LONG = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  logic early = 1'b0;
  logic sel = 1'b0;
  logic ev = 1'b0;
  logic rd_l, wr_l, cs_l, ale, oe_l, rdy_l, irq_l;
  logic [15:0] addr;
  hpp_data_t hd, dout, bus;
  int num_errors = 0;
  int n_checks = 0;

  always #50 clk = ~clk;
  // Data wire level from whoever drives it
  assign bus = (oe_l === 1'b0) ? dout : hd;

  hpp_host_port #(.GAP_LONG_CYC(GAP_LONG)) u_hpp_host_port (.i_clock(clk), .i_reset(rst),
    .i_multiplexed_sync_bus_mode(mode), .i_early_ready(early), .i_irq_gap_timebase_sel(sel),
    .i_irq_event(ev), .i_read_strobe_low(rd_l), .i_write_strobe_low(wr_l), .i_chip_select_low(cs_l),
    .i_addr_latch_enable(ale), .i_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe_low(oe_l),
    .o_ready_out_low(rdy_l), .o_irq_low(irq_l));

  hpp_host_model u_hpp_host_model (.i_clock(clk), .i_ready_low(rdy_l), .i_oe_low(oe_l), .i_bus(bus),
    .o_rd_low(rd_l), .o_wr_low(wr_l), .o_cs_low(cs_l), .o_ale(ale), .o_addr(addr), .o_data(hd));

  // ----
  // Compare and report
  // ----
  task automatic chk8(input hpp_data_t got, input hpp_data_t exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkn(input int v, input int lo, input int hi, input string m);
    n_checks++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("unexpected at %0t: %s count %0d", $time, m, v);
    end
  endtask

  task automatic summarize;
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic do_reset(input logic m);
    @(negedge clk);
    rst = 1'b1;
    mode = m;
    repeat (400) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // Strap moves after it was taken and must be ignored
    mode = ~m;
    repeat (4) @(negedge clk);
    u_hpp_host_model.mux = m;
  endtask

  task automatic rd_exp(input logic [15:0] a, input hpp_data_t exp, output int rl, output int ol);
    hpp_data_t d;
    logic ok;
    u_hpp_host_model.rd(a, d, rl, ol, ok);
    chk8(d, exp, "read data");
    chk8({7'h00, ok}, 8'h01, "bus release");
  endtask

  task automatic wr_ok(input logic [15:0] a, input hpp_data_t dt, input logic cs);
    logic ok;
    u_hpp_host_model.wr(a, dt, cs, ok);
    chk8({7'h00, ok}, 8'h01, "write ready release");
  endtask

  task automatic t_async;
    int rl, ol, ol_ram, rl_n;
    wr_ok(16'h0100, 8'ha5, 1'b0);
    wr_ok(16'h0101, 8'h3c, 1'b0);
    wr_ok(16'h0005, 8'h66, 1'b0);
    wr_ok(16'h0000, 8'hee, 1'b0);
    rd_exp(16'h0101, 8'h3c, rl, ol);
    rd_exp(16'h0100, 8'ha5, rl_n, ol_ram);
    chkn(rl_n, 4, 10, "ready latency");
    rd_exp(16'h0005, 8'h66, rl, ol);
    chkn(ol - ol_ram, 1, 1, "register vs ram latency");
    // Status is read only: idle interrupt, async mode, sequencer in its read state
    rd_exp(16'h0000, 8'h01, rl, ol);
    early = 1'b1;
    rd_exp(16'h0100, 8'ha5, rl, ol);
    chkn(rl_n - rl, 1, 1, "early ready");
    early = 1'b0;
    wr_ok(16'h0100, 8'hff, 1'b1);
    rd_exp(16'h0100, 8'ha5, rl, ol);
  endtask

  task automatic t_irq(input logic s, input int gap);
    int n;
    logic ok;
    sel = s;
    @(negedge clk);
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    repeat (2) @(negedge clk);
    chk8({7'h00, irq_l}, 8'h00, "irq raise");
    n = 0;
    fork
      u_hpp_host_model.wr(16'h0001, 8'h00, 1'b0, ok);
      begin
        @(posedge irq_l);
        @(negedge clk);
        ev = 1'b1;
        @(negedge clk);
        ev = 1'b0;
        while (irq_l !== 1'b0 && n < 2000) begin
          @(posedge clk);
          #1 n++;
        end
      end
    join
    chkn(n + 1, gap, gap + 2, "irq gap");
  endtask

  task automatic t_mux;
    int rl, ol;
    do_reset(1'b1);
    wr_ok(16'h0123, 8'h5a, 1'b1);
    wr_ok(16'h0124, 8'hc3, 1'b1);
    wr_ok(16'h0923, 8'h77, 1'b1);
    rd_exp(16'h0123, 8'h5a, rl, ol);
    chkn(rl, 0, 0, "no ready in mux mode");
    rd_exp(16'h0124, 8'hc3, rl, ol);
  endtask

  initial begin
    do_reset(1'b0);
    t_async();
    t_irq(1'b0, 10);
    t_irq(1'b1, GAP_LONG);
    t_mux();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end
endmodule // hpp_host_port_tb
